/* File: src/pws_params.svh */
// constants for the pwm submodule irq, trigger, fault and deadtime block
`ifndef PWS_PARAMS_SVH
`define PWS_PARAMS_SVH

// register indices, byte address is four times the index
`define PWS_IDX_MODE 8'hA1
`define PWS_IDX_STATUS 8'hA2
`define PWS_IDX_INTEN 8'hA3
`define PWS_IDX_TCTRL 8'hA5
`define PWS_IDX_DISMAP 8'hA6
`define PWS_IDX_DT0 8'hA7
`define PWS_IDX_DT1 8'hA8

// apb address decode
`define PWS_ADDR_W 12
`define PWS_IDX_LSB 2

// reset values
`define PWS_DT_RESET 11'h7FF
`define PWS_DISMAP_RESET 12'hFFF
`define PWS_DISMAP_RO_ONES 4'hF

// writable masks
`define PWS_INTEN_MASK 14'h3FFF
`define PWS_STATUS_MASK 9'h1FF

// status and enable bit positions
`define PWS_BIT_CAPTURE_B0_FLAG 8
`define PWS_BIT_CAPTURE_X1_FLAG 7
`define PWS_BIT_CAPTURE_X0_FLAG 6
`define PWS_CMP_LSB 0
`define PWS_NUM_VAL 6

// fault mask field positions inside the mapping register
`define PWS_A_OUTPUT_FAULT_MASK_LSB 0
`define PWS_B_OUTPUT_FAULT_MASK_LSB 4
`define PWS_AUX_OUTPUT_FAULT_MASK_LSB 8
`define PWS_NUM_FAULT 4

// trigger grouping: values 0,2,4 even, 1,3,5 odd
`define PWS_TRIG_EVEN_SEL 6'h15
`define PWS_TRIG_ODD_SEL 6'h2A

`endif

/* File: src/pws_pkg.sv */
// types shared by the pwm submodule irq, trigger, fault and deadtime block
package pws_pkg;
    // deadtime count in bus clock cycles
    typedef logic [10:0] pws_dt_t;
    // one bus data word
    typedef logic [31:0] pws_word_t;
    // register index taken from the apb address
    typedef logic [7:0] pws_idx_t;
endpackage : pws_pkg

/* File: src/pws_dt_if.sv */
// carrier between the register core and the deadtime stage
`timescale 1ns/10ps
interface pws_dt_if;
    logic comp_mode;
    pws_pkg::pws_dt_t dt_a;
    pws_pkg::pws_dt_t dt_b;
    logic raw_a;
    logic raw_b;
    logic out_a;
    logic out_b;

    // core side drives settings and raw levels
    modport core (
        output comp_mode,
        output dt_a,
        output dt_b,
        output raw_a,
        output raw_b,
        input out_a,
        input out_b
    );

    // stage side inserts deadtime
    modport stage (
        input comp_mode,
        input dt_a,
        input dt_b,
        input raw_a,
        input raw_b,
        output out_a,
        output out_b
    );
endinterface : pws_dt_if

/* File: src/pws_deadtime.sv */
// deadtime insertion stage for the a and b outputs
`timescale 1ns/10ps
`include "pws_params.svh"
module pws_deadtime (
    input wire logic clk,
    input wire logic rst_n,
    pws_dt_if.stage dt
);
    pws_pkg::pws_dt_t cnt_a_r;
    pws_pkg::pws_dt_t cnt_b_r;
    logic out_a_r;
    logic out_b_r;
    logic want_a;
    logic want_b;

    // *********************************************
    // rising-edge delay counter shared by both lanes
    // *********************************************
    function automatic pws_pkg::pws_dt_t next_cnt(
        input logic level,
        input pws_pkg::pws_dt_t cnt,
        input pws_pkg::pws_dt_t limit
    );
        if (!level)
        begin
            return '0;
        end
        if (cnt < limit)
        begin
            return pws_pkg::pws_dt_t'(cnt + 11'h001);
        end
        return cnt;
    endfunction : next_cnt

    // complementary mode drives b from inverted a, else lanes are independent
    always_comb
    begin
        want_a = dt.raw_a;
        want_b = dt.comp_mode ? ~dt.raw_a : dt.raw_b; // see [RL14]
    end

    // lane a delay count in bus clocks
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_a_r <= '0;
        end
        else
        begin
            cnt_a_r <= next_cnt(want_a, cnt_a_r, dt.dt_a); // see [RL15]
        end
    end

    // lane b delay count in bus clocks
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_b_r <= '0;
        end
        else
        begin
            cnt_b_r <= next_cnt(want_b, cnt_b_r, dt.dt_b); // see [RL15]
        end
    end

    // outputs rise once the held count reaches the limit, so a count of n gives n idle cycles
    // deadtime bypassed when independent
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end
        else if (dt.comp_mode)
        begin
            out_a_r <= want_a && (cnt_a_r >= dt.dt_a); // see [RL18]
            out_b_r <= want_b && (cnt_b_r >= dt.dt_b); // see [RL19]
        end
        else
        begin
            out_a_r <= want_a; // see [RL14]
            out_b_r <= want_b;
        end
    end

    assign dt.out_a = out_a_r;
    assign dt.out_b = out_b_r;
endmodule : pws_deadtime

/* File: src/pws_top.sv */
// pwm submodule: interrupt enables, output triggers, fault masks, deadtime
// Function
// [RL1] capture b0 enable gates its status flag onto the interrupt request
// [RL2] enable bit 7 gates capture x1 flag onto the interrupt request
// [RL3] enable bit 6 gates capture x0 flag onto the interrupt request
// [RL4] six compare enables each gate their compare flag onto the request
// [RL5] six trigger enables allow a trigger on counter equal to value n
// [RL6] values 0,2,4 drive even trigger; values 1,3,5 drive odd trigger
// [RL7] trigger stays high only while the counter equals the enabled value
// [RL8] cleared trigger enable means no trigger from that value match
// [RL9] fault mapping bits 15 to 12 read back as one
// [RL10] aux output off when an active fault has its x mask bit set
// [RL11] b output off when an active fault has its b mask bit set
// [RL12] a output off when an active fault has its a mask bit set
// [RL13] reset sets every fault mapping bit to one
// [RL14] deadtime applies only in complementary mode
// [RL15] deadtime counts bus clock cycles, 11 bits
// [RL16] deadtime counts reset to 0x07FF, 2047 cycles
// [RL17] software uses only full word accesses to deadtime counts
// [RL18] first deadtime count delays rising edges of the a output
// [RL19] second deadtime count delays rising edges of the b output
// [RL20] compare flags set on counter match, cleared by writing one
// [RL21] interrupt is or of flags and enables, held until either clears
`timescale 1ns/10ps
`include "pws_params.svh"
module pws_top (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`PWS_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [`PWS_NUM_VAL-1:0] MATCH_VALUE_N,
    input wire logic CAPTURE_X0,
    input wire logic CAPTURE_X1,
    input wire logic CAPTURE_B0,
    input wire logic [`PWS_NUM_FAULT-1:0] FAULT_INPUT_N,
    input wire logic RAW_A,
    input wire logic RAW_B,
    input wire logic RAW_X,
    output logic A_OUTPUT,
    output logic B_OUTPUT,
    output logic AUX_OUTPUT,
    output logic TRIGGER_OUT_EVEN,
    output logic TRIGGER_OUT_ODD,
    output logic IRQ
);
    // *********************************************
    // declarations
    // *********************************************
    logic comp_mode_r;
    logic [8:0] submodule_status_r;
    logic [13:0] interrupt_enable_r;
    logic [5:0] trigger_enables_r;
    logic [11:0] fault_disable_mapping_r;
    pws_pkg::pws_dt_t deadtime_count_a_field_r;
    pws_pkg::pws_dt_t deadtime_count_b_field_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] fault_s1_r;
    logic [3:0] fault_s2_r;
    logic [3:0] fault_s3_r;
    logic [3:0] fault_r;
    logic a_out_r;
    logic b_out_r;
    logic x_out_r;
    logic trig_even_r;
    logic trig_odd_r;
    logic irq_r;
    logic setup;
    logic wr_en;
    pws_pkg::pws_idx_t idx;
    logic [8:0] status_set;
    logic [8:0] status_clr;
    logic [31:0] rd_word;
    logic rd_hit;

    pws_dt_if dt_bus ();

    // *********************************************
    // helpers
    // *********************************************
    // true when any active fault has its mask bit set
    function automatic logic fault_kill(
        input logic [3:0] faults,
        input logic [3:0] mask
    );
        return |(faults & mask);
    endfunction : fault_kill

    // *********************************************
    // apb decode
    // *********************************************
    // setup cycle and access-phase write strobe
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && pready_r && PWRITE;
    assign idx = PADDR[`PWS_IDX_LSB +: 8];

    // read mux, unmapped indices miss
    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (idx)
            `PWS_IDX_MODE: rd_word[0] = comp_mode_r;
            `PWS_IDX_STATUS: rd_word[8:0] = submodule_status_r;
            `PWS_IDX_INTEN: rd_word[13:0] = interrupt_enable_r;
            `PWS_IDX_TCTRL: rd_word[5:0] = trigger_enables_r;
            `PWS_IDX_DISMAP:
            begin
                rd_word[15:12] = `PWS_DISMAP_RO_ONES; // see [RL9]
                rd_word[11:0] = fault_disable_mapping_r;
            end
            `PWS_IDX_DT0: rd_word[10:0] = deadtime_count_a_field_r;
            `PWS_IDX_DT1: rd_word[10:0] = deadtime_count_b_field_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // answer one cycle after setup: ready, data and error from flops
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !rd_hit;
            prdata_r <= (setup && !PWRITE) ? rd_word : 32'h0000_0000;
        end
    end

    // *********************************************
    // control registers
    // *********************************************
    // complementary mode select, off after reset
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            comp_mode_r <= 1'b0;
        end
        else if (wr_en && idx == `PWS_IDX_MODE)
        begin
            comp_mode_r <= PWDATA[0];
        end
    end

    // interrupt enables, bits 15 and 14 stay zero
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            interrupt_enable_r <= '0;
        end
        else if (wr_en && idx == `PWS_IDX_INTEN)
        begin
            interrupt_enable_r <= PWDATA[13:0] & `PWS_INTEN_MASK;
        end
    end

    // trigger enables, one per value register
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            trigger_enables_r <= '0;
        end
        else if (wr_en && idx == `PWS_IDX_TCTRL)
        begin
            trigger_enables_r <= PWDATA[5:0];
        end
    end

    // fault masks, all ones after reset
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            fault_disable_mapping_r <= `PWS_DISMAP_RESET; // see [RL13]
        end
        else if (wr_en && idx == `PWS_IDX_DISMAP)
        begin
            fault_disable_mapping_r <= PWDATA[11:0];
        end
    end

    // deadtime counts, whole word written, upper bits dropped
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            deadtime_count_a_field_r <= `PWS_DT_RESET; // see [RL16]
            deadtime_count_b_field_r <= `PWS_DT_RESET; // see [RL16]
        end
        else if (wr_en && idx == `PWS_IDX_DT0)
        begin
            deadtime_count_a_field_r <= PWDATA[10:0]; // see [RL17]
        end
        else if (wr_en && idx == `PWS_IDX_DT1)
        begin
            deadtime_count_b_field_r <= PWDATA[10:0]; // see [RL17]
        end
    end

    // *********************************************
    // status flags
    // *********************************************
    // event sources and write-one clears
    always_comb
    begin
        status_set = '0;
        status_set[`PWS_BIT_CAPTURE_B0_FLAG] = CAPTURE_B0;
        status_set[`PWS_BIT_CAPTURE_X1_FLAG] = CAPTURE_X1;
        status_set[`PWS_BIT_CAPTURE_X0_FLAG] = CAPTURE_X0;
        status_set[`PWS_CMP_LSB +: `PWS_NUM_VAL] = MATCH_VALUE_N; // see [RL20]
        status_clr = (wr_en && idx == `PWS_IDX_STATUS) ? PWDATA[8:0] : 9'h000;
    end

    // sticky flags, a new event wins over a clear in the same cycle
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            submodule_status_r <= '0;
        end
        else
        begin
            submodule_status_r <= ((submodule_status_r & ~status_clr) | status_set)
                & `PWS_STATUS_MASK; // see [RL20]
        end
    end

    // *********************************************
    // interrupt request
    // *********************************************
    // or of every flag gated by its enable
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= (submodule_status_r[`PWS_BIT_CAPTURE_B0_FLAG] && interrupt_enable_r[`PWS_BIT_CAPTURE_B0_FLAG]) // see [RL1]
                || (submodule_status_r[`PWS_BIT_CAPTURE_X1_FLAG] && interrupt_enable_r[`PWS_BIT_CAPTURE_X1_FLAG]) // see [RL2]
                || (submodule_status_r[`PWS_BIT_CAPTURE_X0_FLAG] && interrupt_enable_r[`PWS_BIT_CAPTURE_X0_FLAG]) // see [RL3]
                || |(submodule_status_r[5:0] & interrupt_enable_r[5:0]); // see [RL4] see [RL21]
        end
    end

    // *********************************************
    // output triggers
    // *********************************************
    // level triggers, high only while an enabled match holds
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            trig_even_r <= 1'b0;
            trig_odd_r <= 1'b0;
        end
        else
        begin
            trig_even_r <= |(MATCH_VALUE_N & trigger_enables_r & `PWS_TRIG_EVEN_SEL); // see [RL5] see [RL6] see [RL7] see [RL8]
            trig_odd_r <= |(MATCH_VALUE_N & trigger_enables_r & `PWS_TRIG_ODD_SEL); // see [RL5] see [RL6] see [RL7] see [RL8]
        end
    end

    // *********************************************
    // fault input synchroniser
    // *********************************************
    // three stages, value accepted when stages two and three agree
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            fault_s1_r <= '0;
            fault_s2_r <= '0;
            fault_s3_r <= '0;
            fault_r <= '0;
        end
        else
        begin
            fault_s1_r <= FAULT_INPUT_N;
            fault_s2_r <= fault_s1_r;
            fault_s3_r <= fault_s2_r;
            for (int i = 0; i < `PWS_NUM_FAULT; i++)
            begin
                if (fault_s2_r[i] == fault_s3_r[i])
                begin
                    fault_r[i] <= fault_s3_r[i];
                end
            end
        end
    end

    // *********************************************
    // deadtime stage
    // *********************************************
    assign dt_bus.comp_mode = comp_mode_r;
    assign dt_bus.dt_a = deadtime_count_a_field_r;
    assign dt_bus.dt_b = deadtime_count_b_field_r;
    assign dt_bus.raw_a = RAW_A;
    assign dt_bus.raw_b = RAW_B;

    pws_deadtime u_deadtime (
        .clk(MCLK),
        .rst_n(RSTN),
        .dt(dt_bus.stage)
    );

    // *********************************************
    // fault masking of the outputs
    // *********************************************
    // any masked active fault forces the output low
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            a_out_r <= 1'b0;
            b_out_r <= 1'b0;
            x_out_r <= 1'b0;
        end
        else
        begin
            a_out_r <= dt_bus.out_a
                && !fault_kill(fault_r, fault_disable_mapping_r[`PWS_A_OUTPUT_FAULT_MASK_LSB +: 4]); // see [RL12]
            b_out_r <= dt_bus.out_b
                && !fault_kill(fault_r, fault_disable_mapping_r[`PWS_B_OUTPUT_FAULT_MASK_LSB +: 4]); // see [RL11]
            x_out_r <= RAW_X
                && !fault_kill(fault_r, fault_disable_mapping_r[`PWS_AUX_OUTPUT_FAULT_MASK_LSB +: 4]); // see [RL10]
        end
    end

    // *********************************************
    // port drive
    // *********************************************
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign A_OUTPUT = a_out_r;
    assign B_OUTPUT = b_out_r;
    assign AUX_OUTPUT = x_out_r;
    assign TRIGGER_OUT_EVEN = trig_even_r;
    assign TRIGGER_OUT_ODD = trig_odd_r;
    assign IRQ = irq_r;
endmodule : pws_top

/* File: dv/pws_top_sva.sv */
// port assertions for the pwm submodule block
`timescale 1ns/10ps
`include "pws_params.svh"
module pws_top_sva (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [`PWS_NUM_VAL-1:0] MATCH_VALUE_N,
    input wire logic CAPTURE_X0,
    input wire logic CAPTURE_X1,
    input wire logic CAPTURE_B0,
    input wire logic RAW_A,
    input wire logic RAW_B,
    input wire logic RAW_X,
    input wire logic A_OUTPUT,
    input wire logic B_OUTPUT,
    input wire logic AUX_OUTPUT,
    input wire logic TRIGGER_OUT_EVEN,
    input wire logic TRIGGER_OUT_ODD,
    input wire logic IRQ
);
    // ****************
    // checks
    // ****************
    logic cause;
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);
    // anything that may set a flag or an enable
    assign cause = CAPTURE_X0 | CAPTURE_X1 | CAPTURE_B0 | (|MATCH_VALUE_N) | (PREADY & PWRITE);
    AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE && $past(!PENABLE))
        else $error("ready outside access cycle");
    AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_TRIG_EVEN: assert property (TRIGGER_OUT_EVEN |-> $past(|(MATCH_VALUE_N & 6'h15)))
        else $error("even trigger without even match");
    AST_TRIG_ODD: assert property (TRIGGER_OUT_ODD |-> $past(|(MATCH_VALUE_N & 6'h2A)))
        else $error("odd trigger without odd match");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> $past(cause, 2))
        else $error("interrupt rose without cause");
    AST_A_RAW: assert property (A_OUTPUT |-> $past(RAW_A, 2))
        else $error("a output high without raw a");
    AST_B_RAW: assert property (B_OUTPUT |-> $past(RAW_B, 2) || !$past(RAW_A, 2))
        else $error("b output high without source");
    AST_X_RAW: assert property (AUX_OUTPUT |-> $past(RAW_X))
        else $error("aux output high without raw x");
endmodule : pws_top_sva

bind pws_top pws_top_sva pws_top_sva_inst (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PRDATA,
    .PREADY, .PSLVERR, .MATCH_VALUE_N, .CAPTURE_X0, .CAPTURE_X1, .CAPTURE_B0, .RAW_A, .RAW_B,
    .RAW_X, .A_OUTPUT, .B_OUTPUT, .AUX_OUTPUT, .TRIGGER_OUT_EVEN, .TRIGGER_OUT_ODD, .IRQ);

/* File: dv/pws_stage_model.sv */
// power stage model: fault sensing and leg overlap watch
`timescale 1ns/10ps
module pws_stage_model (
    input wire logic clk,
    input wire logic comp_mode,
    input wire logic a_drive,
    input wire logic b_drive,
    input wire logic [3:0] trip,
    output logic [3:0] fault,
    output int overlap
);
    // ****************
    // stage
    // ****************
    initial fault = 4'h0;
    initial overlap = 0;
    // fault pins report the sensors one cycle late, idle low
    always @(posedge clk) fault <= trip;
    // both switches of a complementary leg on means shoot-through
    always @(posedge clk) if (comp_mode && a_drive && b_drive) overlap <= overlap + 1;
endmodule : pws_stage_model

/* File: dv/pws_top_tb.sv */
// self-checking bench for the pwm submodule block
`timescale 1ns/10ps
`include "pws_params.svh"
module pws_top_tb;
    // ****************
    // signals and parts
    // ****************
    logic MCLK = 1'h0, RSTN = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, A_OUTPUT, B_OUTPUT, AUX_OUTPUT, TRIGGER_OUT_EVEN, TRIGGER_OUT_ODD, IRQ;
    logic [5:0] MATCH_VALUE_N = 6'h0;
    logic CAPTURE_X0 = 1'h0, CAPTURE_X1 = 1'h0, CAPTURE_B0 = 1'h0;
    logic RAW_A = 1'h0, RAW_B = 1'h0, RAW_X = 1'h0, comp = 1'h0, er;
    logic [3:0] FAULT_INPUT_N;
    logic [3:0] trip = 4'h0;
    logic [31:0] rd;
    int overlap;
    int err_count = 0;
    int cmp_count = 0;
    always #20 MCLK = ~MCLK;
    pws_top pws_top_inst (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .MATCH_VALUE_N, .CAPTURE_X0, .CAPTURE_X1, .CAPTURE_B0,
        .FAULT_INPUT_N, .RAW_A, .RAW_B, .RAW_X, .A_OUTPUT, .B_OUTPUT, .AUX_OUTPUT,
        .TRIGGER_OUT_EVEN, .TRIGGER_OUT_ODD, .IRQ);
    pws_stage_model pws_stage_model_inst (.clk(MCLK), .comp_mode(comp), .a_drive(A_OUTPUT),
        .b_drive(B_OUTPUT), .trip(trip), .fault(FAULT_INPUT_N), .overlap(overlap));
    // ****************
    // tasks
    // ****************
    task results;
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one full-word apb transfer, held until ready
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= {2'h0, idx, 2'h0};
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        n = 0;
        do
        begin
            @(posedge MCLK);
            n++;
        end
        while (PREADY !== 1'h1 && n < 16);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        if (PREADY !== 1'h1)
        begin
            err_count++;
            results();
        end
    endtask : apb
    task rc(input logic [7:0] idx, input logic [31:0] exp, input string what);
        apb(1'h0, idx, 32'h0);
        chk(what, exp, rd);
    endtask : rc
    task cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : cyc
    // one-cycle pulse on capture and match sources
    task ev(input logic [8:0] m);
        @(posedge MCLK);
        {CAPTURE_B0, CAPTURE_X1, CAPTURE_X0, MATCH_VALUE_N} <= m;
        @(posedge MCLK);
        {CAPTURE_B0, CAPTURE_X1, CAPTURE_X0, MATCH_VALUE_N} <= 9'h0;
    endtask : ev
    // ****************
    // sequence
    // ****************
    initial
    begin
        int n;
        repeat (3) @(posedge MCLK);
        RSTN <= 1'h1;
        rc(`PWS_IDX_STATUS, 32'h0, "status");
        rc(`PWS_IDX_INTEN, 32'h0, "inten");
        rc(`PWS_IDX_TCTRL, 32'h0, "tctrl");
        rc(`PWS_IDX_DISMAP, 32'h0000FFFF, "dismap");
        rc(`PWS_IDX_DT0, 32'h000007FF, "dt a");
        rc(`PWS_IDX_DT1, 32'h000007FF, "dt b");
        apb(1'h1, `PWS_IDX_INTEN, 32'hFFFFFFFF);
        rc(`PWS_IDX_INTEN, 32'h00003FFF, "inten");
        apb(1'h1, `PWS_IDX_DISMAP, 32'h0);
        rc(`PWS_IDX_DISMAP, 32'h0000F000, "dismap");
        apb(1'h1, `PWS_IDX_DT0, 32'hFFFFFFFF);
        rc(`PWS_IDX_DT0, 32'h000007FF, "dt a");
        apb(1'h1, 8'hA4, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, er);
        rc(8'hA4, 32'h0, "unmapped");
        apb(1'h1, `PWS_IDX_INTEN, 32'h0);
        // each trigger enable alone while every value matches
        for (n = 0; n < 6; n++)
        begin
            apb(1'h1, `PWS_IDX_TCTRL, 32'h1 << n);
            ev(9'h03F);
            #1;
            chk("trig even", n % 2 == 0, TRIGGER_OUT_EVEN);
            chk("trig odd", n % 2 == 1, TRIGGER_OUT_ODD);
            cyc(1);
            chk("trig drop", 32'h0, {TRIGGER_OUT_EVEN, TRIGGER_OUT_ODD});
        end
        apb(1'h1, `PWS_IDX_TCTRL, 32'h0);
        // each flag gated by its own enable only
        for (n = 0; n < 9; n++)
        begin
            apb(1'h1, `PWS_IDX_STATUS, 32'h1FF);
            apb(1'h1, `PWS_IDX_INTEN, 32'h1 << n);
            ev(9'h1FF & ~(9'h1 << n));
            cyc(3);
            chk("irq blocked", 32'h0, IRQ);
            rc(`PWS_IDX_STATUS, 32'h1FF & ~(32'h1 << n), "status");
            ev(9'h1 << n);
            cyc(3);
            chk("irq raised", 32'h1, IRQ);
            apb(1'h1, `PWS_IDX_INTEN, 32'h0);
            cyc(2);
            chk("irq disabled", 32'h0, IRQ);
            apb(1'h1, `PWS_IDX_INTEN, 32'h1 << n);
            apb(1'h1, `PWS_IDX_STATUS, 32'h1 << n);
            cyc(2);
            chk("irq cleared", 32'h0, IRQ);
        end
        // one fault per output through the mapping masks
        apb(1'h1, `PWS_IDX_DISMAP, 32'h421);
        RAW_A <= 1'h1;
        RAW_B <= 1'h1;
        RAW_X <= 1'h1;
        for (n = 0; n < 5; n++)
        begin
            trip <= (n < 4) ? 4'h1 << n : 4'h0;
            cyc(12);
            chk("a output", n != 0, A_OUTPUT);
            chk("b output", n != 1, B_OUTPUT);
            chk("aux output", n != 2, AUX_OUTPUT);
        end
        // deadtime on both rising edges in complementary mode
        apb(1'h1, `PWS_IDX_DT0, 32'h5);
        apb(1'h1, `PWS_IDX_DT1, 32'h3);
        RAW_A <= 1'h0;
        apb(1'h1, `PWS_IDX_MODE, 32'h1);
        cyc(20);
        comp <= 1'h1;
        chk("b comp", 32'h1, B_OUTPUT);
        @(posedge MCLK);
        RAW_A <= 1'h1;
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end
        while (A_OUTPUT !== 1'h1 && n < 60);
        chk("a rise delay", 32'h7, n);
        @(posedge MCLK);
        RAW_A <= 1'h0;
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end
        while (B_OUTPUT !== 1'h1 && n < 60);
        chk("b rise delay", 32'h5, n);
        chk("overlap", 32'h0, overlap);
        @(posedge MCLK);
        comp <= 1'h0;
        RAW_A <= 1'h1;
        apb(1'h1, `PWS_IDX_MODE, 32'h0);
        cyc(4);
        chk("independent", 32'h3, {A_OUTPUT, B_OUTPUT});
        results();
    end
endmodule : pws_top_tb
